/* core/irq_pkg.sv */
// constants and carrier types for the interrupt enable and request-latch block
package irq_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_EN_S32  = 8'h2A;
  localparam logic [7:0] ADDR_IL_S32  = 8'h2B;
  localparam logic [7:0] ADDR_EN_S16  = 8'h2C;
  localparam logic [7:0] ADDR_EN_S24  = 8'h2D;
  localparam logic [7:0] ADDR_IL_S16  = 8'h2E;
  localparam logic [7:0] ADDR_IL_S24  = 8'h2F;
  localparam logic [7:0] ADDR_EN_LOW  = 8'h3A;
  localparam logic [7:0] ADDR_EN_S8   = 8'h3B;
  localparam logic [7:0] ADDR_IL_LOW  = 8'h3C;
  localparam logic [7:0] ADDR_IL_S8   = 8'h3D;
  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int          NSRC        = 40;
  localparam int          GATE_BIT    = 0;
  localparam int          NEST_LSB    = 0;
  localparam int          FIXED_SRC   = 2;
  localparam logic [39:0] EN_MASK     = 40'hFF_FFFF_BF68;
  localparam logic [39:0] IL_MASK     = 40'hFF_FFFF_BF6C;
  localparam logic [39:0] NMI_MASK    = 40'h00_0000_0004;
  localparam logic [39:0] EN_RESET    = 40'h00_0000_0000;
  localparam logic        GATE_RESET  = 1'b0;
  localparam logic [3:0]  NEST_RESET  = 4'h0;
  localparam logic [1:0]  NEST_CLEAR  = 2'h1;
  localparam logic [1:0]  NEST_DEC    = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_NS      = 10;
  localparam int          MCYC_NS     = 200;
  localparam int          MCYC_CLKS   = (MCYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ACCEPT_MCYC = 12;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic       accept;
    logic [5:0] accept_src;
    logic       accept_nolatch;
    logic       gate_on;
    logic       gate_off;
    logic       mask_ret;
    logic       nmi_ret;
  } core_ev_type;
endpackage

/* core/request_latch.sv */
// one interrupt request latch with write-zero and acceptance clearing
module request_latch #(
  parameter bit PRESENT = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  logic q_reg;
  logic q_next;

  // a new request beats a clear landing in the same cycle
  assign q_next = PRESENT & (set | (q_reg & ~clr));
  assign q      = q_reg;

  always_ff @(posedge clk) begin
    if (rst) q_reg <= 1'b0;
    else     q_reg <= q_next;
  end
endmodule

/* core/irq_enable_latch.sv */
// interrupt gate, enable bits, request latches and nesting counter
//
// Notes on behaviour
// - pseudo non-maskable sources are offered whatever gate and enable bits hold.
// - five enable bytes, plain reads and writes, reads have no side effects.
// - gate at zero blocks every maskable request.
// - maskable latch offered only when gate and its own enable are one.
// - acceptance hands current gate to stacking, then clears the gate.
// - maskable return sets the gate so pending requests follow at once.
// - non-maskable return restores the gate saved at pseudo-NMI acceptance.
// - gate is bit 0 of the low enable byte, read/write, reset zero.
// - gate-on sets the gate, gate-off clears it.
// - each enable bit passes or blocks its own maskable source.
// - reset clears all enable bits of sources 3 to 39.
// - latch reads its pending state; write zero clears, write one ignored.
// - source two latch is not cleared by a write on its own.
// - nesting field reads 00 idle, 01 in first-level service.
// - nesting write 01 clears counter, 10 decrements without underflow check.
// - counter starts at zero, counts up on accept, down on return.
// - latches for 16-31 in a byte pair, 32-39 in one byte, reset zero.
// - enables for 16-31 in a byte pair, 32-39 in one byte, reset zero.
// - latch sets on request and clears when its source is accepted.
// - acceptance sequence takes twelve machine cycles.
module irq_enable_latch
  import irq_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire irq_pkg::sfr_req_type sfr,
  input  wire irq_pkg::core_ev_type ev,
  input  wire logic [39:0]          src_req,
  output logic [7:0]                sfr_rdata,
  output logic [39:0]               offer,
  output logic                      stack_gate,
  output logic                      accept_busy
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [39:0] en_reg;
  logic [39:0] en_next;
  logic        gate_reg;
  logic        gate_next;
  logic        nmi_gate_reg;
  logic [3:0]  nest_reg;
  logic [3:0]  nest_next;
  logic [7:0]  rdata_reg;
  logic [39:0] offer_reg;
  logic        stack_gate_reg;
  logic        busy_reg;
  logic [4:0]  mcyc_reg;
  logic [3:0]  seq_reg;
  logic [39:0] latch;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [4:0] en_hit;
  logic [4:0] il_hit;
  logic [4:0] en_we;
  logic [4:0] il_we;
  logic       mapped;

  assign en_hit = {sfr.addr == ADDR_EN_S32, sfr.addr == ADDR_EN_S24,
                   sfr.addr == ADDR_EN_S16, sfr.addr == ADDR_EN_S8,
                   sfr.addr == ADDR_EN_LOW};
  assign il_hit = {sfr.addr == ADDR_IL_S32, sfr.addr == ADDR_IL_S24,
                   sfr.addr == ADDR_IL_S16, sfr.addr == ADDR_IL_S8,
                   sfr.addr == ADDR_IL_LOW};
  assign en_we  = en_hit & {5{sfr.wr}};
  assign il_we  = il_hit & {5{sfr.wr}};
  assign mapped = |{en_hit, il_hit};

  // ------------------------------------------------------------
  // acceptance decode
  // ------------------------------------------------------------
  logic [39:0] acc_onehot;
  logic        acc_nmi;

  assign acc_onehot = ev.accept_nolatch ? 40'h00_0000_0000
                      : (40'h00_0000_0001 << ev.accept_src);
  assign acc_nmi    = ev.accept & (ev.accept_nolatch | |(acc_onehot & NMI_MASK));

  // ------------------------------------------------------------
  // request latches
  // ------------------------------------------------------------
  logic [39:0] wr_clr;
  logic        fixed_clr_ok;

  // the fixed source clears only alongside another latch cleared in its byte
  assign fixed_clr_ok = |(~sfr.wdata[7:3] & IL_MASK[7:3]);

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_latch
      if (i == FIXED_SRC) begin : g_fixed
        assign wr_clr[i] = il_we[i / 8] & ~sfr.wdata[i % 8] & fixed_clr_ok;
      end else begin : g_plain
        assign wr_clr[i] = il_we[i / 8] & ~sfr.wdata[i % 8];
      end
      request_latch #(
        .PRESENT (IL_MASK[i])
      ) u_latch (
        .clk (clk),
        .rst (rst),
        .set (src_req[i]),
        .clr (wr_clr[i] | (ev.accept & acc_onehot[i])),
        .q   (latch[i])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // enable bits
  // ------------------------------------------------------------
  logic [39:0] en_wmask;

  assign en_wmask = {{8{en_we[4]}}, {8{en_we[3]}}, {8{en_we[2]}},
                     {8{en_we[1]}}, {8{en_we[0]}}};
  // unimplemented positions stay zero so they read back as zero
  assign en_next  = ((en_reg & ~en_wmask) | ({5{sfr.wdata}} & en_wmask)) & EN_MASK;

  always_ff @(posedge clk) begin
    if (rst) en_reg <= EN_RESET;
    else     en_reg <= en_next;
  end

  // ------------------------------------------------------------
  // master gate: acceptance beats everything else in the cycle
  // ------------------------------------------------------------
  assign gate_next = ev.accept   ? 1'b0
                   : ev.nmi_ret  ? nmi_gate_reg
                   : ev.mask_ret ? 1'b1
                   : ev.gate_on  ? 1'b1
                   : ev.gate_off ? 1'b0
                   : en_we[0]    ? sfr.wdata[GATE_BIT]
                   : gate_reg;

  // gate value at acceptance goes out to stacking before it clears
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_reg       <= GATE_RESET;
      stack_gate_reg <= GATE_RESET;
      nmi_gate_reg   <= GATE_RESET;
    end else begin
      gate_reg <= gate_next;
      if (ev.accept) stack_gate_reg <= gate_reg;
      if (acc_nmi)   nmi_gate_reg   <= gate_reg;
    end
  end

  // ------------------------------------------------------------
  // nesting counter; wraps silently, no underflow flag exists
  // ------------------------------------------------------------
  logic       nest_wr;
  logic [1:0] nest_field;
  logic       ret_any;

  assign nest_wr = il_we[0];
  assign ret_any = ev.mask_ret | ev.nmi_ret;
  assign nest_next =
      (nest_wr && sfr.wdata[1:0] == NEST_CLEAR) ? NEST_RESET
    : (nest_wr && sfr.wdata[1:0] == NEST_DEC)   ? nest_reg - 4'h1
    : (ev.accept && !ret_any) ? nest_reg + 4'h1
    : (ret_any && !ev.accept) ? nest_reg - 4'h1
    : nest_reg;
  assign nest_field = (nest_reg > 4'h3) ? 2'h3 : nest_reg[1:0];

  always_ff @(posedge clk) begin
    if (rst) nest_reg <= NEST_RESET;
    else     nest_reg <= nest_next;
  end

  // ------------------------------------------------------------
  // acceptance sequence timer, in machine cycles
  // ------------------------------------------------------------
  logic mcyc_tick;

  assign mcyc_tick = (mcyc_reg == 5'(MCYC_CLKS - 1));

  // divider free-runs so machine cycles keep a fixed phase
  always_ff @(posedge clk) begin
    if (rst || mcyc_tick) mcyc_reg <= 5'h00;
    else                  mcyc_reg <= mcyc_reg + 5'h01;
  end

  // offers are held back while the core runs its acceptance sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      seq_reg  <= 4'h0;
    end else if (ev.accept) begin
      busy_reg <= 1'b1;
      seq_reg  <= 4'h0;
    end else if (busy_reg && mcyc_tick) begin
      seq_reg <= seq_reg + 4'h1;
      if (seq_reg == 4'(ACCEPT_MCYC - 1)) busy_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // offer to the core
  // ------------------------------------------------------------
  logic [39:0] maskable_ok;
  logic [39:0] offer_next;

  assign maskable_ok = {40{gate_reg}} & en_reg;
  assign offer_next  = (busy_reg | ev.accept) ? 40'h00_0000_0000  // accepting edge is already held back
                     : latch & (maskable_ok | NMI_MASK);

  always_ff @(posedge clk) begin
    if (rst) offer_reg <= 40'h00_0000_0000;
    else     offer_reg <= offer_next;
  end

  // ------------------------------------------------------------
  // read path; reads never disturb state
  // ------------------------------------------------------------
  logic [7:0] en_rd;
  logic [7:0] il_rd;
  logic [7:0] rd_mux;

  assign en_rd = en_hit[0] ? {en_reg[7:1], gate_reg}
               : en_hit[1] ? en_reg[15:8]
               : en_hit[2] ? en_reg[23:16]
               : en_hit[3] ? en_reg[31:24]
               : en_reg[39:32];
  assign il_rd = il_hit[0] ? {latch[7:2], nest_field}
               : il_hit[1] ? latch[15:8]
               : il_hit[2] ? latch[23:16]
               : il_hit[3] ? latch[31:24]
               : latch[39:32];
  assign rd_mux = !mapped ? 8'h00 : (|en_hit ? en_rd : il_rd);

  always_ff @(posedge clk) begin
    if (rst)         rdata_reg <= 8'h00;
    else if (sfr.rd) rdata_reg <= rd_mux;
  end

  assign sfr_rdata   = rdata_reg;
  assign offer       = offer_reg;
  assign stack_gate  = stack_gate_reg;
  assign accept_busy = busy_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // helper state for the checks: gate seen at pseudo-NMI acceptance, sequence length
  logic       nmi_low_reg;
  logic [8:0] busy_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst)          nmi_low_reg <= 1'b0;
    else if (acc_nmi) nmi_low_reg <= ~gate_reg;
  end

  // a counter, since a repetition this long would choke the checker
  always_ff @(posedge clk) begin
    if (rst) busy_cnt_reg <= 9'h000;
    else     busy_cnt_reg <= (busy_reg && !ev.accept) ? busy_cnt_reg + 9'h001 : 9'h000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_gate_blocks: assert property (!gate_reg |=> (offer_reg & ~NMI_MASK) == 40'h0)
    else $error("maskable offer with gate low");
  chk_offer_cause: assert property (##1 (offer_reg & ~NMI_MASK) != 40'h0
                                     |-> $past(gate_reg) && !$past(busy_reg))
    else $error("maskable offer without cause");
  chk_nmi_bypass: assert property (latch[FIXED_SRC] && !busy_reg && !ev.accept |=> offer_reg[FIXED_SRC])
    else $error("pseudo non-maskable not offered");
  chk_accept_gate: assert property (ev.accept |=> !gate_reg && stack_gate_reg == $past(gate_reg))
    else $error("gate not stacked and cleared");
  chk_maskable_return_op_gate: assert property (ev.mask_ret && !ev.accept && !ev.nmi_ret |=> gate_reg)
    else $error("maskable return left gate low");
  chk_nonmaskable_return_op_gate: assert property (ev.nmi_ret && !ev.accept && nmi_low_reg |=> !gate_reg)
    else $error("non-maskable return raised gate");
  chk_set_wins: assert property (src_req[16] && wr_clr[16] |=> latch[16])
    else $error("request lost to clear");
  chk_fixed_alone: assert property (il_we[0] && sfr.wdata[7:3] == 5'h1F && latch[FIXED_SRC]
                                     |=> latch[FIXED_SRC])
    else $error("fixed latch cleared alone");
  chk_nest_count: assert property (ev.accept && !ret_any && !nest_wr |=> nest_reg == $past(nest_reg) + 4'h1)
    else $error("nesting counter did not count up");
  chk_busy_bound: assert property ($fell(busy_reg)
                                   |-> $past(busy_cnt_reg) >= 9'((ACCEPT_MCYC - 1) * MCYC_CLKS))
    else $error("acceptance sequence ended early");
  chk_busy_ends: assert property (busy_reg |-> busy_cnt_reg < 9'(ACCEPT_MCYC * MCYC_CLKS))
    else $error("acceptance sequence timer stuck");

  cov_nested: cover property (ev.accept ##[1:300] ev.accept && nest_reg == 4'h1);
  cov_nonmaskable_return_op: cover property (acc_nmi ##[1:300] ev.nmi_ret);
  cov_latch_clear: cover property (il_we[2] && latch[16] ##1 !latch[16]);
endmodule

/* bench/core_model.sv */
// cpu core model: instruction events and interrupt acceptance
module core_model (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [2:0]      cmd,
  input  wire logic            auto_acc,
  input  wire logic [3:0]      lag,
  input  wire logic [39:0]     offer,
  input  wire logic            accept_busy,
  output irq_pkg::core_ev_type ev = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt = 4'h0;
  int         pick;

  // events launch off the falling edge, one instruction per cycle
  always @(negedge clk) begin
    ev <= '0;
    if (rst) begin
      wait_cnt <= 4'h0;
    // nothing is taken while a sequence runs
    end else if (auto_acc && offer != '0 && !accept_busy) begin
      // a slow core lets the offer stand a few cycles
      if (wait_cnt < lag) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        pick = 0;
        // lowest number wins, standing in for the priority logic
        while (!offer[pick]) pick++;
        ev.accept     <= 1'b1;
        ev.accept_src <= 6'(pick);
        wait_cnt      <= 4'h0;
      end
    end else begin
      ev.gate_on        <= (cmd == 3'h1);
      ev.gate_off       <= (cmd == 3'h2);
      ev.mask_ret       <= (cmd == 3'h3);
      ev.nmi_ret        <= (cmd == 3'h4);
      ev.accept         <= (cmd == 3'h5);
      ev.accept_nolatch <= (cmd == 3'h5);
    end
  end
endmodule

/* bench/irq_enable_latch_nesting_tb_top.sv */
// self-checking bench: registers, gating, acceptance and nesting
module irq_enable_latch_nesting_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  sfr_req_type sfr = '0;
  core_ev_type ev;
  logic [39:0] src_req = '0;
  logic [7:0]  sfr_rdata;
  logic [39:0] offer;
  logic        stack_gate;
  logic        accept_busy;
  logic [2:0]  cmd = 3'h0;
  logic        auto_acc = 1'b0;
  logic [3:0]  lag = 4'h0;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;
  // address tables; 0x30 is unmapped
  logic [7:0]  amap [11] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h30};
  logic [7:0]  en_a [6] = '{8'h2A, 8'h2C, 8'h2D, 8'h3B, 8'h3A, 8'h3A};
  logic [7:0]  en_w [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h68, 8'h01};
  logic [7:0]  en_r [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'h68, 8'h01};
  logic [7:0]  la [5] = '{8'h3C, 8'h3D, 8'h2E, 8'h2F, 8'h2B};
  logic [7:0]  lr [5] = '{8'h6C, 8'hBF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  nw [6] = '{8'hFE, 8'hFE, 8'hFD, 8'hFE, 8'hFF, 8'hFD};
  logic [7:0]  nr [6] = '{8'h03, 8'h02, 8'h00, 8'h03, 8'h03, 8'h00};

  irq_enable_latch DUT (
    .clk(clk), .rst(rst), .sfr(sfr), .ev(ev), .src_req(src_req), .sfr_rdata(sfr_rdata),
    .offer(offer), .stack_gate(stack_gate), .accept_busy(accept_busy)
  );
  core_model core (
    .clk(clk), .rst(rst), .cmd(cmd), .auto_acc(auto_acc), .lag(lag),
    .offer(offer), .accept_busy(accept_busy), .ev(ev)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // hang guard: a run this long means a lost handshake
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes are one cycle wide, launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    sfr = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    sfr = '0;
    chk(40'(sfr_rdata), 40'(exp));
  endtask

  // core reads cmd on the falling edge, so it changes by nonblocking update
  task automatic op(input logic [2:0] c);
    @(negedge clk);
    cmd <= c;
    @(negedge clk);
    cmd <= 3'h0;
    @(negedge clk);
  endtask

  // one-cycle request, returns once the offer has caught up
  task automatic pulse(input logic [39:0] v);
    @(negedge clk);
    src_req = v;
    @(negedge clk);
    src_req = '0;
    @(negedge clk);
  endtask

  // length of the acceptance sequence in clocks
  task automatic wait_busy();
    n = 0;
    while (accept_busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (accept_busy === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(40'((n >= 221) && (n <= 240)), 40'h1);
  endtask

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    // every byte starts at zero
    foreach (amap[i]) rd(amap[i], 8'h00);
    // gate stays low while enables change; gate written alone last
    foreach (en_a[i]) begin
      wr(en_a[i], en_w[i]);
      rd(en_a[i], en_r[i]);
    end
    for (int i = 5; i >= 0; i--) wr(en_a[i], 8'h00);
    // latches: catch, ignore ones, clear on zeros; source two needs company
    pulse('1);
    foreach (la[i]) rd(la[i], lr[i]);
    wr(8'h2B, 8'hFF);
    rd(8'h2B, 8'hFF);
    wr(8'h2B, 8'h00);
    rd(8'h2B, 8'h00);
    wr(8'h3C, 8'h68);
    rd(8'h3C, 8'h6C);
    wr(8'h3C, 8'h60);
    rd(8'h3C, 8'h60);
    foreach (la[i]) wr(la[i], 8'h00);
    // offer needs gate and own enable; pseudo non-maskable ignores both
    wr(8'h2C, 8'h01);
    pulse(40'h3_0000);
    chk(offer, 40'h0);
    op(3'h1);
    @(negedge clk);
    chk(offer, 40'h1_0000);
    op(3'h2);
    @(negedge clk);
    chk(offer, 40'h0);
    pulse(40'h4);
    chk(offer, 40'h4);
    wr(8'h3C, 8'h00);
    @(negedge clk);
    chk(offer, 40'h0);
    // slow core takes source 16, then a maskable return lets 17 through
    op(3'h1);
    lag <= 4'h3;
    auto_acc <= 1'b1;
    wait_busy();
    auto_acc <= 1'b0;
    chk(40'(stack_gate), 40'h1);
    rd(8'h3A, 8'h00);
    rd(8'h2E, 8'h02);
    rd(8'h3C, 8'h01);
    wr(8'h2C, 8'h03);
    op(3'h3);
    @(negedge clk);
    chk(offer, 40'h2_0000);
    rd(8'h3C, 8'h00);
    op(3'h2);
    wr(8'h2C, 8'h00);
    wr(8'h2E, 8'h00);
    // four levels deep, then field writes including an underflow
    for (int i = 0; i < 4; i++) begin
      op(3'h5);
      wait_busy();
      rd(8'h3C, (i < 3) ? 8'(i + 1) : 8'h03);
    end
    foreach (nw[i]) begin
      wr(8'h3C, nw[i]);
      rd(8'h3C, nr[i]);
    end
    // non-maskable return brings back the gate seen at acceptance
    for (int g = 1; g >= 0; g--) begin
      op(g ? 3'h1 : 3'h2);
      op(3'h5);
      wait_busy();
      chk(40'(stack_gate), 40'(g));
      rd(8'h3A, 8'h00);
      op(3'h4);
      rd(8'h3A, 8'(g));
    end
    end_of_test();
  end
endmodule
